// ---- design/mid_decoder.sv ----
/*
 * instruction decoder: splits 14-bit words into byte, bit and literal/control forms,
 * extracts operand fields and sequences one- or two-cycle execution.
 * assumes program memory presents insn_word valid at each cycle boundary and the
 * execute stage reports branch_taken (skip true or pc changed) by the last period.
 */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - each instruction is one 14-bit word
// - d=0 result to accumulator, d=1 to file
// - file address field spans 0x00..0x7f
// - bit field selects one of eight bits
// - literal is eight or eleven bits
// - ignored bits decode the same either way
// - one cycle, two when branch or skip
// - instruction cycle is four oscillator periods
// - exactly one of four groups per word
// - port read-modify-write reads pin levels
// - add literal sums into accumulator
module mid_decoder (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [mid_pkg::INSN_W-1:0] insn_word,
    input wire logic branch_taken,
    output logic [1:0] group_r,
    output logic [mid_pkg::INSN_W-1:0] insn_r,
    output logic [3:0] op_r,
    output logic [mid_pkg::FILE_W-1:0] file_addr_r,
    output logic dest_file_r,
    output logic dest_acc_r,
    output logic [7:0] bit_mask_r,
    output logic [mid_pkg::LIT8_W-1:0] lit8_r,
    output logic [mid_pkg::LIT11_W-1:0] lit11_r,
    output logic read_pins_r,
    output logic acc_add_lit_r,
    output logic flush_r,
    output logic cycle_strobe_r
);
    logic [1:0] phase;
    logic cycle_end;

    mid_qdiv #(.PERIODS(mid_pkg::Q_PER_CYCLE)) u_mid_qdiv (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    typedef enum logic {MID_RUN, MID_BUBBLE} mid_state_t;
    mid_state_t state_r, state_nxt;

    // group from the two top opcode bits
    function automatic logic [1:0] grp_of(input logic [13:0] w);
        return w[mid_pkg::OP_HI:mid_pkg::OP_LO];
    endfunction

    // classify a word; don't-care bits are never looked at
    function automatic mid_pkg::mid_op_t op_of(input logic [13:0] w);
        mid_pkg::mid_op_t o;
        o = mid_pkg::MID_OP_NOP;
        unique case (grp_of(w))
            mid_pkg::GRP_BYTE: begin
                if (w[11:8] == mid_pkg::SUB_MOVE && !w[mid_pkg::DEST_POS]) begin
                    // nop with x bits masked out
                    if ((w & 14'h3f9f) == mid_pkg::WORD_NOP) o = mid_pkg::MID_OP_NOP;
                    else if (w == mid_pkg::WORD_RETURN) o = mid_pkg::MID_OP_RET;
                    else if (w == mid_pkg::WORD_RET_INT) o = mid_pkg::MID_OP_RET;
                    else if (w == mid_pkg::WORD_SLEEP) o = mid_pkg::MID_OP_SLEEP;
                    else if (w == mid_pkg::WORD_WDOG_CLR) o = mid_pkg::MID_OP_WDOG_CLR;
                    else o = mid_pkg::MID_OP_NOP; // reserved
                end else if (w[11:8] == mid_pkg::SUB_CLR && !w[mid_pkg::DEST_POS]
                             && w != mid_pkg::WORD_ACC_CLR) begin
                    o = mid_pkg::MID_OP_NOP; // reserved
                end else begin
                    o = mid_pkg::MID_OP_BYTE;
                end
            end
            mid_pkg::GRP_BIT: begin
                o = w[11] ? mid_pkg::MID_OP_BITTEST : mid_pkg::MID_OP_BITSET;
            end
            mid_pkg::GRP_JUMP: begin
                o = w[11] ? mid_pkg::MID_OP_GOTO : mid_pkg::MID_OP_CALL;
            end
            mid_pkg::GRP_LIT: begin
                // masks drop the x bits of each literal form
                if (w[11:9] == 3'h7) o = mid_pkg::MID_OP_ADDLIT;
                else if (w[11:10] == 2'h0) o = mid_pkg::MID_OP_LIT;
                else if (w[11:10] == 2'h1) o = mid_pkg::MID_OP_RET;
                else if (w[11:9] == 3'h6) o = mid_pkg::MID_OP_LIT;
                else if (w[11:8] == mid_pkg::LSUB_AND || w[11:8] == mid_pkg::LSUB_IOR
                         || w[11:8] == mid_pkg::LSUB_XOR) o = mid_pkg::MID_OP_LIT;
                else o = mid_pkg::MID_OP_NOP; // reserved
            end
        endcase
        return o;
    endfunction

    logic [mid_pkg::INSN_W-1:0] insn_nxt;
    logic [3:0] op_nxt;
    logic [1:0] group_nxt;
    logic [mid_pkg::FILE_W-1:0] file_nxt;
    logic dfile_nxt, dacc_nxt, pins_nxt, addl_nxt, flush_nxt, strobe_nxt;
    logic [7:0] mask_nxt;
    logic [mid_pkg::LIT8_W-1:0] lit8_nxt;
    logic [mid_pkg::LIT11_W-1:0] lit11_nxt;
    mid_pkg::mid_op_t op_w;
    logic writes_dest;

    always_comb begin
        state_nxt = state_r;
        insn_nxt = insn_r;
        op_nxt = op_r;
        group_nxt = group_r;
        file_nxt = file_addr_r;
        dfile_nxt = dest_file_r;
        dacc_nxt = dest_acc_r;
        mask_nxt = bit_mask_r;
        lit8_nxt = lit8_r;
        lit11_nxt = lit11_r;
        pins_nxt = read_pins_r;
        addl_nxt = acc_add_lit_r;
        flush_nxt = 1'b0;
        strobe_nxt = 1'b0;
        op_w = op_of(insn_word);
        // only a write back to the file is a read-modify-write of a port
        writes_dest = (op_w == mid_pkg::MID_OP_BITSET) ||
            (op_w == mid_pkg::MID_OP_BYTE && insn_word[mid_pkg::DEST_POS]);
        if (cycle_end) begin
            strobe_nxt = 1'b1;
            unique case (state_r)
                MID_RUN: begin
                    if (branch_taken) begin
                        // drop the prefetched word, run a nop next
                        state_nxt = MID_BUBBLE;
                        flush_nxt = 1'b1;
                        insn_nxt = mid_pkg::WORD_NOP;
                        op_nxt = mid_pkg::MID_OP_NOP;
                        group_nxt = mid_pkg::GRP_BYTE;
                        dfile_nxt = 1'b0;
                        dacc_nxt = 1'b0;
                        pins_nxt = 1'b0;
                        addl_nxt = 1'b0;
                    end else begin
                        insn_nxt = insn_word;
                        op_nxt = op_w;
                        group_nxt = grp_of(insn_word);
                        file_nxt = insn_word[mid_pkg::FILE_W-1:0];
                        dfile_nxt = (op_w == mid_pkg::MID_OP_BITSET) ||
                            (op_w == mid_pkg::MID_OP_BYTE && insn_word[mid_pkg::DEST_POS]);
                        dacc_nxt = (op_w == mid_pkg::MID_OP_BYTE
                            && !insn_word[mid_pkg::DEST_POS]);
                        mask_nxt = 8'h01 << insn_word[mid_pkg::BIT_LO +: mid_pkg::BIT_W];
                        lit8_nxt = insn_word[mid_pkg::LIT8_W-1:0];
                        lit11_nxt = insn_word[mid_pkg::LIT11_W-1:0];
                        pins_nxt = writes_dest;
                        addl_nxt = (op_w == mid_pkg::MID_OP_ADDLIT);
                    end
                end
                MID_BUBBLE: begin
                    // second cycle behaves as nop, decode resumes at new pc
                    state_nxt = MID_RUN;
                    insn_nxt = insn_word;
                    op_nxt = op_w;
                    group_nxt = grp_of(insn_word);
                    file_nxt = insn_word[mid_pkg::FILE_W-1:0];
                    dfile_nxt = (op_w == mid_pkg::MID_OP_BITSET) ||
                        (op_w == mid_pkg::MID_OP_BYTE && insn_word[mid_pkg::DEST_POS]);
                    dacc_nxt = (op_w == mid_pkg::MID_OP_BYTE && !insn_word[mid_pkg::DEST_POS]);
                    mask_nxt = 8'h01 << insn_word[mid_pkg::BIT_LO +: mid_pkg::BIT_W];
                    lit8_nxt = insn_word[mid_pkg::LIT8_W-1:0];
                    lit11_nxt = insn_word[mid_pkg::LIT11_W-1:0];
                    pins_nxt = writes_dest;
                    addl_nxt = (op_w == mid_pkg::MID_OP_ADDLIT);
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= MID_RUN;
            insn_r <= mid_pkg::WORD_NOP;
            op_r <= mid_pkg::MID_OP_NOP;
            group_r <= mid_pkg::GRP_BYTE;
            file_addr_r <= '0;
            dest_file_r <= 1'b0;
            dest_acc_r <= 1'b0;
            bit_mask_r <= 8'h01;
            lit8_r <= '0;
            lit11_r <= '0;
            read_pins_r <= 1'b0;
            acc_add_lit_r <= 1'b0;
            flush_r <= 1'b0;
            cycle_strobe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            insn_r <= insn_nxt;
            op_r <= op_nxt;
            group_r <= group_nxt;
            file_addr_r <= file_nxt;
            dest_file_r <= dfile_nxt;
            dest_acc_r <= dacc_nxt;
            bit_mask_r <= mask_nxt;
            lit8_r <= lit8_nxt;
            lit11_r <= lit11_nxt;
            read_pins_r <= pins_nxt;
            acc_add_lit_r <= addl_nxt;
            flush_r <= flush_nxt;
            cycle_strobe_r <= strobe_nxt;
        end
    end

    flush_nop_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        flush_r |-> (op_r == mid_pkg::MID_OP_NOP) && !dest_file_r ##4 !flush_r)
        else $error("flush did not insert a single nop cycle");
    strobe_period_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cycle_strobe_r |=> !cycle_strobe_r [*3] ##1 cycle_strobe_r)
        else $error("cycle strobe not every four periods");
    dest_onehot_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(dest_file_r && dest_acc_r))
        else $error("result sent to both destinations");
    dest_sel_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (op_r == mid_pkg::MID_OP_BYTE) |-> (dest_file_r == insn_r[mid_pkg::DEST_POS]))
        else $error("destination select mismatch");
    bit_mask_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        $onehot(bit_mask_r))
        else $error("bit mask not one-hot");
    file_field_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cycle_strobe_r && !flush_r |-> file_addr_r == insn_r[mid_pkg::FILE_W-1:0])
        else $error("file address field wrong");
    lit_field_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cycle_strobe_r && !flush_r |-> lit11_r == insn_r[mid_pkg::LIT11_W-1:0]
            && lit8_r == insn_r[mid_pkg::LIT8_W-1:0])
        else $error("literal fields disagree");
    strobe_phase_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cycle_strobe_r |-> (phase == 2'h0))
        else $error("cycle strobe off the phase boundary");
    group_field_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cycle_strobe_r |-> group_r == insn_r[mid_pkg::OP_HI:mid_pkg::OP_LO])
        else $error("group code wrong");
    addlit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        acc_add_lit_r |-> insn_r[13:9] == 5'h1f)
        else $error("add literal flagged on wrong word");
endmodule
`default_nettype wire

// ---- design/mid_pkg.sv ----
/*
 * constants for the instruction decoder: field positions, group codes, timing.
 * assumes a 14-bit instruction word from program memory.
 */
`default_nettype none
package mid_pkg;
    localparam int INSN_W = 14;
    localparam int FILE_W = 7;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int BIT_W = 3;
    localparam int OP_HI = 13;
    localparam int OP_LO = 12;
    localparam int DEST_POS = 7;
    localparam int BIT_LO = 7;
    localparam int Q_PER_CYCLE = 4;
    localparam logic [1:0] GRP_BYTE = 2'h0;
    localparam logic [1:0] GRP_BIT = 2'h1;
    localparam logic [1:0] GRP_JUMP = 2'h2;
    localparam logic [1:0] GRP_LIT = 2'h3;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [13:0] WORD_NOP = 14'h0000;
    localparam logic [13:0] WORD_RETURN = 14'h0008;
    localparam logic [13:0] WORD_RET_INT = 14'h0009;
    localparam logic [13:0] WORD_SLEEP = 14'h0063;
    localparam logic [13:0] WORD_WDOG_CLR = 14'h0064;
    localparam logic [13:0] WORD_ACC_CLR = 14'h0103;
    localparam logic [3:0] SUB_MOVE = 4'h0;
    localparam logic [3:0] SUB_CLR = 4'h1;
    localparam logic [3:0] SUB_DEC_SKIP = 4'hb;
    localparam logic [3:0] SUB_INC_SKIP = 4'hf;
    localparam logic [1:0] BSUB_TSTC = 2'h2;
    localparam logic [1:0] BSUB_TSTS = 2'h3;
    localparam logic [3:0] LSUB_RET_LIT = 4'h4;
    localparam logic [3:0] LSUB_ADD = 4'he;
    localparam logic [3:0] LSUB_AND = 4'h9;
    localparam logic [3:0] LSUB_IOR = 4'h8;
    localparam logic [3:0] LSUB_XOR = 4'ha;
    localparam logic [3:0] LSUB_SUB = 4'hc;
    localparam logic [3:0] LSUB_MOV = 4'h0;
    typedef enum logic [3:0] {
        MID_OP_NOP, MID_OP_BYTE, MID_OP_BITSET, MID_OP_BITTEST, MID_OP_CALL,
        MID_OP_GOTO, MID_OP_LIT, MID_OP_ADDLIT, MID_OP_RET, MID_OP_SLEEP, MID_OP_WDOG_CLR
    } mid_op_t;
endpackage
`default_nettype wire

// ---- design/mid_qdiv.sv ----
/*
 * quarter-phase divider: splits the core clock into four-period instruction cycles.
 * assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
`default_nettype none
module mid_qdiv #(
    parameter int PERIODS = mid_pkg::Q_PER_CYCLE
) (
    input wire logic core_clk,
    input wire logic arst_n,
    output logic [1:0] phase,
    output logic cycle_end
);
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;

    always_comb begin
        phase_nxt = (phase_r == 2'(PERIODS - 1)) ? 2'h0 : 2'(phase_r + 2'h1);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign phase = phase_r;
    assign cycle_end = (phase_r == 2'(PERIODS - 1));

    phase_wrap_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (phase_r == 2'(PERIODS - 1)) |=> (phase_r == 2'h0))
        else $error("phase did not wrap after four periods");
endmodule
`default_nettype wire

// ---- tb/mid_prog_mem.sv ----
/*
 * program memory and execute-stage model for the decoder.
 * assumes the decoder strobes once per instruction cycle and flags bubbles.
 */
`timescale 1ns/1ns
`default_nettype none
module mid_prog_mem (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cycle_strobe,
    input wire logic flush,
    output logic [13:0] insn_word,
    output logic branch_taken
);
    // holds assigned opcodes, reserved ones only where a scenario asks
    logic [13:0] mem [0:15];
    logic take [0:15];
    logic [3:0] pc_r = 4'h0;
    logic [3:0] exec_r = 4'h0;
    logic exec_ok_r = 1'b0;

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 14'h0000;
            take[i] = 1'b0;
        end
    end

    assign insn_word = mem[pc_r];
    // a bubble never takes a branch itself
    assign branch_taken = exec_ok_r & take[exec_r];

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_r <= 4'h0;
            exec_r <= 4'h0;
            exec_ok_r <= 1'b0;
        end else if (cycle_strobe) begin
            pc_r <= #1 pc_r + 4'h1;
            exec_r <= #1 pc_r;
            exec_ok_r <= #1 !flush;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_mid_decoder.sv ----
/*
 * self-checking bench for the instruction decoder.
 * assumes the program memory model in mid_prog_mem and a 100 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_mid_decoder;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [13:0] insn_word;
    logic branch_taken;
    logic [1:0] group_r;
    logic [13:0] insn_r;
    logic [3:0] op_r;
    logic [6:0] file_addr_r;
    logic dest_file_r;
    logic dest_acc_r;
    logic [7:0] bit_mask_r;
    logic [7:0] lit8_r;
    logic [10:0] lit11_r;
    logic read_pins_r;
    logic acc_add_lit_r;
    logic flush_r;
    logic cycle_strobe_r;
    int miscompares = 0;
    int n_compared = 0;
    logic [13:0] ew [0:15];
    mid_pkg::mid_op_t eo [0:15];
    logic ef [0:15];

    always #5 core_clk = ~core_clk;

    mid_decoder u_mid_decoder (.core_clk(core_clk), .arst_n(arst_n), .insn_word(insn_word),
        .branch_taken(branch_taken), .group_r(group_r), .insn_r(insn_r), .op_r(op_r),
        .file_addr_r(file_addr_r), .dest_file_r(dest_file_r), .dest_acc_r(dest_acc_r),
        .bit_mask_r(bit_mask_r), .lit8_r(lit8_r), .lit11_r(lit11_r),
        .read_pins_r(read_pins_r), .acc_add_lit_r(acc_add_lit_r), .flush_r(flush_r),
        .cycle_strobe_r(cycle_strobe_r));

    mid_prog_mem u_mid_prog_mem (.core_clk(core_clk), .arst_n(arst_n),
        .cycle_strobe(cycle_strobe_r), .flush(flush_r), .insn_word(insn_word),
        .branch_taken(branch_taken));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic put(input int i, input logic [13:0] w, input mid_pkg::mid_op_t o);
        u_mid_prog_mem.mem[i] = w;
        u_mid_prog_mem.take[i] = 1'b0;
        ew[i] = w;
        eo[i] = o;
        ef[i] = 1'b0;
    endtask

    task automatic expect_step(input int i);
        logic byte_op;
        logic wr;
        int s;
        byte_op = (eo[i] == mid_pkg::MID_OP_BYTE);
        wr = (byte_op & ew[i][7]) | (eo[i] == mid_pkg::MID_OP_BITSET);
        // a bubble leaves the operand fields of the word before it in place
        s = ef[i] ? i - 1 : i;
        check("insn", 32'(insn_r), 32'(ew[i]));
        check("group", 32'(group_r), 32'(ew[i][13:12]));
        check("op", 32'(op_r), 32'(eo[i]));
        check("file_addr", 32'(file_addr_r), 32'(ew[s][6:0]));
        check("dest_file", 32'(dest_file_r), 32'(wr));
        check("dest_acc", 32'(dest_acc_r), 32'(byte_op & !ew[i][7]));
        check("bit_mask", 32'(bit_mask_r), 32'(8'h01 << ew[s][9:7]));
        check("lit8", 32'(lit8_r), 32'(ew[s][7:0]));
        check("lit11", 32'(lit11_r), 32'(ew[s][10:0]));
        check("read_pins", 32'(read_pins_r), 32'(wr));
        check("add_lit", 32'(acc_add_lit_r), 32'(eo[i] == mid_pkg::MID_OP_ADDLIT));
        check("flush", 32'(flush_r), 32'(ef[i]));
    endtask

    // restart the core and compare every instruction cycle against the table
    task automatic run(input int n);
        int gap;
        @(posedge core_clk);
        #1 arst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 arst_n = 1'b1;
        for (int i = 0; i < n; i++) begin
            gap = 0;
            do begin
                @(posedge core_clk);
                #1;
                gap++;
            end while (cycle_strobe_r !== 1'b1 && gap < 8);
            check("strobe_gap", 32'(gap), 32'(mid_pkg::Q_PER_CYCLE));
            expect_step(i);
        end
    endtask

    task automatic sc_reset();
        check("rst_op", 32'(op_r), 32'(mid_pkg::MID_OP_NOP));
        check("rst_mask", 32'(bit_mask_r), 32'h1);
        check("rst_strobe", 32'(cycle_strobe_r), 32'h0);
    endtask

    task automatic sc_byte();
        put(0, {2'b00, 4'h7, 1'b1, 7'h7f}, mid_pkg::MID_OP_BYTE);
        put(1, {2'b00, 4'h7, 1'b0, 7'h00}, mid_pkg::MID_OP_BYTE);
        put(2, {2'b00, 4'h3, 1'b1, 7'h25}, mid_pkg::MID_OP_BYTE);
        put(3, {2'b00, 4'h4, 1'b0, 7'h40}, mid_pkg::MID_OP_BYTE);
        put(4, 14'h0100, mid_pkg::MID_OP_NOP);
        put(5, 14'h0009, mid_pkg::MID_OP_RET);
        put(6, 14'h0080, mid_pkg::MID_OP_BYTE);
        put(7, 14'h0103, mid_pkg::MID_OP_BYTE);
        run(8);
    endtask

    task automatic sc_bit();
        for (int b = 0; b < 8; b++)
            put(b, {2'b01, 2'b01, 3'(b), 7'h0a}, mid_pkg::MID_OP_BITSET);
        put(8, {2'b01, 2'b11, 3'h7, 7'h7f}, mid_pkg::MID_OP_BITTEST);
        put(9, {2'b01, 2'b00, 3'h3, 7'h00}, mid_pkg::MID_OP_BITSET);
        run(10);
    endtask

    task automatic sc_lit();
        put(0, 14'h30a5, mid_pkg::MID_OP_LIT);
        put(1, 14'h33a5, mid_pkg::MID_OP_LIT);
        put(2, 14'h3e5a, mid_pkg::MID_OP_ADDLIT);
        put(3, 14'h3f5a, mid_pkg::MID_OP_ADDLIT);
        put(4, 14'h2fff, mid_pkg::MID_OP_GOTO);
        put(5, 14'h2123, mid_pkg::MID_OP_CALL);
        put(6, 14'h0000, mid_pkg::MID_OP_NOP);
        put(7, 14'h0060, mid_pkg::MID_OP_NOP);
        put(8, 14'h3b77, mid_pkg::MID_OP_NOP);
        put(9, 14'h0008, mid_pkg::MID_OP_RET);
        put(10, 14'h0063, mid_pkg::MID_OP_SLEEP);
        put(11, 14'h0064, mid_pkg::MID_OP_WDOG_CLR);
        put(12, 14'h39ff, mid_pkg::MID_OP_LIT);
        put(13, 14'h3455, mid_pkg::MID_OP_RET);
        put(14, 14'h3d80, mid_pkg::MID_OP_LIT);
        put(15, 14'h3a0f, mid_pkg::MID_OP_LIT);
        run(16);
    endtask

    // skip and jump each drop the prefetched word and leave a bubble
    task automatic sc_branch();
        put(0, {2'b00, 4'hb, 1'b1, 7'h10}, mid_pkg::MID_OP_BYTE);
        put(1, 14'h3012, mid_pkg::MID_OP_NOP);
        put(2, 14'h2805, mid_pkg::MID_OP_GOTO);
        put(3, 14'h3111, mid_pkg::MID_OP_NOP);
        put(4, 14'h3e01, mid_pkg::MID_OP_ADDLIT);
        u_mid_prog_mem.take[0] = 1'b1;
        u_mid_prog_mem.take[2] = 1'b1;
        ew[1] = 14'h0000;
        ef[1] = 1'b1;
        ew[3] = 14'h0000;
        ef[3] = 1'b1;
        run(5);
    endtask

    initial begin
        #20000;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        sc_reset();
        sc_byte();
        sc_bit();
        sc_lit();
        sc_branch();
        complete_run();
    end
endmodule
`default_nettype wire
